// >>> count_clock_divider.sv
// Derives the watchdog count clock as a one-cycle tick from the base oscillator clock.
// Assumes clk_i is the base oscillator clock; restart_i realigns the tick phase.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_map.svh"

module count_clock_divider
  import watchdog_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [2:0] divide_i,
  input wire logic restart_i,
  output logic tick_o
);

  div_state_t s_reg;
  div_state_t s_next;
  logic [3:0] last;
  logic valid_div;

  // Only the two supported settings produce ticks; others freeze the count
  always_comb
  begin
    s_next = s_reg;
    valid_div = 1'b1;
    last = `WDT_RATIO9_LAST;
    unique case (divide_i)
      `WDT_DIV_BY9: last = `WDT_RATIO9_LAST;
      `WDT_DIV_BY11: last = `WDT_RATIO11_LAST;
      default: valid_div = 1'b0;
    endcase
    s_next.tick = 1'b0;
    if (restart_i || !valid_div)
    begin
      s_next.phase = 4'h0;
    end
    else if (s_reg.phase == last)
    begin
      s_next.phase = 4'h0;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.phase = s_reg.phase + 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign tick_o = s_reg.tick;

endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the watchdog time-out core over classic Wishbone.
// Assumes a short early base count of 4 ticks so every interval stays brief.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic early_warning_o;
  logic timeout_o;
  logic irq_o;
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] rd;
  int n;
  // Rows: code, divide, ratio, irq enable; codes stay out of the reserved range
  logic [3:0] rows [4][4] = '{'{4'h0, 4'h4, 4'h9, 4'h1}, '{4'h1, 4'h4, 4'h9, 4'h0},
                              '{4'h2, 4'h5, 4'hb, 4'h0}, '{4'h3, 4'h5, 4'hb, 4'h1}};

  always #2 clk_i = ~clk_i;

  watchdog_timeout_prescaler #(.EARLY_BASE_TICKS(22'h000004)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .early_warning_o(early_warning_o), .timeout_o(timeout_o), .irq_o(irq_o)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; waits on ack, takes data at that edge, then releases
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50)
      fail_count++;
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Edges until the chosen pulse is seen; bounded so a dead pulse cannot hang
  task automatic wait_pulse(input logic fin, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk_i);
      cnt++;
    end
    while ((fin ? timeout_o : early_warning_o) !== 1'b1 && cnt < 2000);
    if (cnt >= 2000)
      fail_count++;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    // About six times the longest expected run
    #40000;
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    wb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h00000040);
    wb(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'h0);
    // Final interval must be base << code count clock periods of the row's ratio
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 8'h00, 32'h0, rd);
      wb(1'b1, 8'h0c, 32'h3, rd);
      wb(1'b1, 8'h10, {31'h0, rows[i][3][0]}, rd);
      wb(1'b1, 8'h00, {23'h0, 1'b1, 1'b0, rows[i][1][2:0], rows[i][0]}, rd);
      wait_pulse(1'b0, n);
      // Three cycles of start latency: enable register, restart, divider phase
      chk(n, (32'h4 << rows[i][0]) * rows[i][2] + 32'h3);
      wait_pulse(1'b1, n);
      chk(n, (32'h4 << rows[i][0]) * rows[i][2]);
      @(posedge clk_i);
      chk(irq_o, rows[i][3][0]);
      wb(1'b0, 8'h08, 32'h0, rd);
      chk(rd, 32'h3);
    end
    // Restart from the expired state gives a fresh early wait, two cycles late
    wb(1'b1, 8'h04, 32'h1, rd);
    wait_pulse(1'b0, n);
    chk(n, (32'h4 << 4'h3) * 32'hb + 32'h2);
    // Clearing both status bits drops the interrupt
    wb(1'b1, 8'h0c, 32'h3, rd);
    wb(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'h0);
    chk(irq_o, 1'b0);
    // Unmapped word reads zero and still acks
    wb(1'b1, 8'h3c, 32'hffffffff, rd);
    wb(1'b0, 8'h3c, 32'h0, rd);
    chk(rd, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

// >>> watchdog_map.svh
// Address map, field positions, reset values and timing constants of the watchdog time-out block.
// Assumes inclusion by bare name from the package and from the modules that decode registers.
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// Word addresses on the Wishbone bus, bits 7:2 of the byte address
`define WDT_ADDR_CONTROL 6'h00
`define WDT_ADDR_RESTART 6'h01
`define WDT_ADDR_STATUS 6'h02
`define WDT_ADDR_CLEAR 6'h03
`define WDT_ADDR_IRQ_EN 6'h04
`define WDT_ADDR_COUNT 6'h05

// Control register field positions
`define WDT_SEL_LSB 0
`define WDT_SEL_MSB 3
`define WDT_DIV_LSB 4
`define WDT_DIV_MSB 6
`define WDT_EN_BIT 8
`define WDT_RESTART_BIT 0

// Status, clear and enable share one layout
`define WDT_EV_EARLY 0
`define WDT_EV_FINAL 1

// Reset values
`define WDT_SEL_RST 4'h0
`define WDT_DIV_RST 3'h4
`define WDT_EV_RST 2'h0

// Divide settings and their ratios of the base oscillator clock
`define WDT_DIV_BY9 3'h4
`define WDT_DIV_BY11 3'h5
`define WDT_RATIO9_LAST 4'h8
`define WDT_RATIO11_LAST 4'ha

// Prescale codes and counts in watchdog clock cycles
`define WDT_SEL_MAX 4'h9
`define WDT_EARLY_BASE 22'h000800
`define WDT_TICK_W 22

`endif

// >>> watchdog_monitor.sv
// Checker for the watchdog time-out core, watching only its top-level ports.
// Assumes clk_i is the single clock and resetn_i the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module watchdog_monitor
#(
  parameter logic [21:0] EARLY_BASE_TICKS = 22'h000800
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic early_warning_o,
  input wire logic timeout_o
);
  logic [31:0] since_early_reg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Cycles since the last early pulse; saturates so a long idle never wraps
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      since_early_reg <= 32'h0;
    else if (early_warning_o)
      since_early_reg <= 32'h1;
    else if (since_early_reg != 32'hffffffff)
      since_early_reg <= since_early_reg + 32'h1;

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_ack_once;
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus access not acked for exactly one cycle");
  // Final interval is a whole number of count clock periods of 9 or 11
  property p_final_ratio;
    timeout_o |-> (since_early_reg % 9 == 0) || (since_early_reg % 11 == 0);
  endproperty
  a_final_ratio: assert property (p_final_ratio) else $error("final interval not a count clock multiple");
  property p_final_span;
    timeout_o |-> since_early_reg >= 32'(EARLY_BASE_TICKS) * 9;
  endproperty
  a_final_span: assert property (p_final_span) else $error("final time-out came too soon after early");
  property p_pulses_apart;
    early_warning_o |-> !timeout_o ##1 !early_warning_o;
  endproperty
  a_pulses_apart: assert property (p_pulses_apart) else $error("early pulse overlaps final or repeats");
endmodule

bind watchdog_timeout_prescaler watchdog_monitor #(.EARLY_BASE_TICKS(EARLY_BASE_TICKS)) u_mon (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .early_warning_o(early_warning_o),
  .timeout_o(timeout_o)
);
`default_nettype wire

// >>> watchdog_pkg.sv
// Types shared by the watchdog time-out core and its count clock divider.
// Assumes watchdog_map.svh is found on the include path.
`default_nettype none
`include "watchdog_map.svh"

package watchdog_pkg;

  // Gray coded along idle, early wait, final wait, expired
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EARLY = 2'b01,
    ST_FINAL = 2'b11,
    ST_EXPIRED = 2'b10
  } wdt_state_t;

  typedef struct packed {
    logic [3:0] timeout_select;
    logic [2:0] divide;
    logic enable;
    logic [1:0] status;
    logic [1:0] irq_en;
    wdt_state_t state;
    logic [`WDT_TICK_W-1:0] ticks;
    logic ack;
    logic [31:0] rdata;
    logic early_pulse;
    logic final_pulse;
    logic restart;
  } core_state_t;

  typedef struct packed {
    logic [3:0] phase;
    logic tick;
  } div_state_t;

endpackage
`default_nettype wire

// >>> watchdog_timeout_prescaler.sv
// Watchdog time-out core: Wishbone registers, early warning and final time-out, interrupt.
// Assumes a classic Wishbone master on clk_i and that clk_i is the base oscillator clock.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_map.svh"

// Register words, byte offsets on the bus:
//   0x00 control: [3:0] time-out select, [6:4] count clock divide, [8] enable
//   0x04 restart, write only: bit 0 zeroes the count and starts a new early wait
//   0x08 status, read only: bit 0 early warning seen, bit 1 final time-out seen
//   0x0c clear, write only: a one clears the matching status bit
//   0x10 interrupt enable: same layout as status
//   0x14 count, read only: watchdog clock ticks since the last start
// Every access is acked one cycle after it is taken, mapped or not.
// Reserved select codes run as the longest code; software should not use them.
// Unsupported divide settings freeze the count, so the watchdog never fires.

module watchdog_timeout_prescaler
  import watchdog_pkg::*;
#(
  parameter logic [`WDT_TICK_W-1:0] EARLY_BASE_TICKS = `WDT_EARLY_BASE
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic early_warning_o,
  output logic timeout_o,
  output logic irq_o
);

  core_state_t s_reg;
  core_state_t s_next;
  logic tick;
  logic take;
  logic wr;
  logic [5:0] word;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  logic [`WDT_TICK_W-1:0] early_lim;
  logic [`WDT_TICK_W-1:0] ticks_inc;
  logic tick_live;

  // Early warning count for a prescale code; reserved codes clamp to the longest
  function automatic logic [`WDT_TICK_W-1:0] early_count(input logic [3:0] code);
    logic [3:0] c;
    c = code;
    // Clamp keeps the shift inside the count width whatever software writes
    if (c > `WDT_SEL_MAX)
      c = `WDT_SEL_MAX;
    return EARLY_BASE_TICKS << c;
  endfunction

  // Count clock ticks from the base clock; restart realigns the phase
  count_clock_divider u_div (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .divide_i(s_reg.divide),
    .restart_i(s_reg.restart),
    .tick_o(tick)
  );

  // Bus decode, register file, time-out sequencing
  always_comb
  begin
    s_next = s_reg;
    take = wb_cyc_i && wb_stb_i && !s_reg.ack;
    wr = take && wb_we_i;
    word = wb_adr_i[7:2];
    early_lim = early_count(s_reg.timeout_select);
    ticks_inc = s_reg.ticks + 22'h000001;
    // A tick landing in the restart cycle belongs to the old phase, so it is dropped
    tick_live = tick && !s_reg.restart;
    ev_set = 2'h0;
    ev_clr = 2'h0;
    // One ack per access; a strobe held through the ack is not taken twice
    s_next.ack = take;
    // Read data stands only in the ack cycle, zero otherwise
    s_next.rdata = 32'h00000000;
    s_next.early_pulse = 1'b0;
    s_next.final_pulse = 1'b0;
    s_next.restart = 1'b0;

    // Register writes; byte lanes gate the control fields
    if (wr)
    begin
      unique case (word)
        `WDT_ADDR_CONTROL:
        begin
          // Select and divide share the low lane; enable sits in the next
          if (wb_sel_i[0])
          begin
            s_next.timeout_select = wb_dat_i[`WDT_SEL_MSB:`WDT_SEL_LSB];
            s_next.divide = wb_dat_i[`WDT_DIV_MSB:`WDT_DIV_LSB];
          end
          if (wb_sel_i[1])
            s_next.enable = wb_dat_i[`WDT_EN_BIT];
        end
        `WDT_ADDR_CLEAR:
          if (wb_sel_i[0])
            ev_clr = wb_dat_i[`WDT_EV_FINAL:`WDT_EV_EARLY];
        `WDT_ADDR_IRQ_EN:
          if (wb_sel_i[0])
            s_next.irq_en = wb_dat_i[`WDT_EV_FINAL:`WDT_EV_EARLY];
        default:
        begin
          // Restart acts on the sequence below; read-only words ignore writes
        end
      endcase
    end

    // Reads; unmapped and write-only words read as zero
    if (take && !wb_we_i)
    begin
      unique case (word)
        `WDT_ADDR_CONTROL:
        begin
          s_next.rdata[`WDT_SEL_MSB:`WDT_SEL_LSB] = s_reg.timeout_select;
          s_next.rdata[`WDT_DIV_MSB:`WDT_DIV_LSB] = s_reg.divide;
          s_next.rdata[`WDT_EN_BIT] = s_reg.enable;
        end
        `WDT_ADDR_STATUS: s_next.rdata[`WDT_EV_FINAL:`WDT_EV_EARLY] = s_reg.status;
        `WDT_ADDR_IRQ_EN: s_next.rdata[`WDT_EV_FINAL:`WDT_EV_EARLY] = s_reg.irq_en;
        `WDT_ADDR_COUNT: s_next.rdata[`WDT_TICK_W-1:0] = s_reg.ticks;
        default: s_next.rdata = 32'h00000000;
      endcase
    end

    // Time-out sequence, counted in watchdog clock ticks
    // Disable has the last word: it stops the count whatever else happens
    if (!s_reg.enable)
    begin
      s_next.state = ST_IDLE;
      s_next.ticks = '0;
    end
    // Restart wins over the running count, from any state
    else if (wr && word == `WDT_ADDR_RESTART && wb_sel_i[0] && wb_dat_i[`WDT_RESTART_BIT])
    begin
      s_next.state = ST_EARLY;
      s_next.ticks = '0;
      s_next.restart = 1'b1;
    end
    else
    begin
      unique case (s_reg.state)
        ST_IDLE:
        begin
          // Enable just rose; the divider phase restarts with the count
          s_next.state = ST_EARLY;
          s_next.ticks = '0;
          s_next.restart = 1'b1;
        end
        ST_EARLY:
          if (tick_live)
          begin
            s_next.ticks = ticks_inc;
            if (ticks_inc == early_lim)
            begin
              s_next.early_pulse = 1'b1;
              ev_set[`WDT_EV_EARLY] = 1'b1;
              s_next.state = ST_FINAL;
            end
          end
        ST_FINAL:
          if (tick_live)
          begin
            s_next.ticks = ticks_inc;
            // A second equal interval, so the final comes at twice the early count
            if (ticks_inc == {early_lim[`WDT_TICK_W-2:0], 1'b0})
            begin
              s_next.final_pulse = 1'b1;
              ev_set[`WDT_EV_FINAL] = 1'b1;
              s_next.state = ST_EXPIRED;
            end
          end
        // Both pulses given; nothing more fires until restart or disable
        ST_EXPIRED:
          s_next.ticks = s_reg.ticks; // Holds until restart or disable
      endcase
    end

    // Sticky events, bit by bit; a set in the clearing cycle wins
    for (int b = `WDT_EV_EARLY; b <= `WDT_EV_FINAL; b++)
    begin
      s_next.status[b] = ev_set[b] || (s_reg.status[b] && !ev_clr[b]);
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // Constants only, so the reset branch stays a plain preset
      s_reg <= '0;
      s_reg.timeout_select <= `WDT_SEL_RST;
      s_reg.divide <= `WDT_DIV_RST;
      s_reg.status <= `WDT_EV_RST;
      s_reg.irq_en <= `WDT_EV_RST;
      s_reg.state <= ST_IDLE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Bus answer and pulses straight from flip-flops, one cycle each
  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign early_warning_o = s_reg.early_pulse;
  assign timeout_o = s_reg.final_pulse;
  // Level interrupt from registered status and enables
  assign irq_o = |(s_reg.status & s_reg.irq_en);

endmodule
`default_nettype wire
